/* rtl/bfs_pkg.sv */
// Shared constants, types and helpers of the buck fault supervisor
package bfs_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int OV_QUAL_MIN_NS  = 1000;
	localparam int OV_QUAL_MAX_NS  = 2000;
	// Least time rounds up
	localparam int OV_QUAL_CYC     = (OV_QUAL_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OV_CNT_W        = 9;
	localparam int HICCUP_MS       = 200;
	localparam longint HICCUP_CYC_L = (64'(HICCUP_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
	localparam int HICCUP_CYC      = int'(HICCUP_CYC_L);
	localparam int HICCUP_CNT_W    = 26;

	// ****************************************
	// Skip window
	// ****************************************
	localparam int SKIP_WINDOW     = 8;
	localparam int SKIP_LIMIT      = 3;
	localparam logic [7:0] SKIP_WINDOW_RST = 8'h00;

	// ****************************************
	// Comparator flag positions
	// ****************************************
	localparam int FLG_HIGH_SIDE_OVERCURRENT   = 0;
	localparam int FLG_LOW_SIDE_OVERCURRENT   = 1;
	localparam int FLG_NEGOC  = 2;
	localparam int FLG_FBOV   = 3;
	localparam int FLG_FBUV   = 4;
	localparam int FLG_FBWIN  = 5;
	localparam int FLG_PVRISE = 6;
	localparam int FLG_PVFALL = 7;
	localparam int FLG_AVLOW  = 8;
	localparam int FLG_AVOK   = 9;
	localparam int FLG_OT     = 10;
	localparam int FLG_OTCOOL = 11;
	localparam int FLG_SSDONE = 12;
	localparam int FLG_ZERO   = 13;
	localparam int FLG_W      = 14;

	// ****************************************
	// State types
	// ****************************************
	typedef enum logic [3:0] {
		BFS_POR    = 4'h1,
		BFS_SOFT   = 4'h2,
		BFS_RUN    = 4'h4,
		BFS_HICCUP = 4'h8
	} bfs_state_type;

	typedef enum logic [2:0] {
		BFS_NEG_IDLE = 3'h1,
		BFS_NEG_HS   = 3'h2,
		BFS_NEG_OFF  = 3'h4
	} bfs_neg_type;

	function automatic logic [3:0] bfs_count_ones(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < SKIP_WINDOW; i++)
			n = n + {3'h0, v[i]};
		return n;
	endfunction : bfs_count_ones

endpackage : bfs_pkg

/* rtl/bfs_skip_if.sv */
// Signals between the supervisor and its skip-window counter
`timescale 1ns/1ps
interface bfs_skip_if;
	logic pwm_tick;
	logic skipped;
	logic clear;
	logic fault;

	modport supervisor (output pwm_tick, output skipped, output clear, input fault);
	modport counter    (input pwm_tick, input skipped, input clear, output fault);
endinterface : bfs_skip_if

/* rtl/bfs_skip_window.sv */
// Sliding eight-cycle window of skipped high-side cycles
`timescale 1ns/1ps
module bfs_skip_window
	import bfs_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// Supervisor side
	bfs_skip_if.counter sk
);

	logic [7:0] window_r;
	logic [7:0] window_nxt;
	logic       fault_r;
	logic       fault_nxt;

	always_comb
	begin
		window_nxt = window_r;
		fault_nxt  = fault_r;
		if (sk.clear)
		begin
			window_nxt = SKIP_WINDOW_RST;
			fault_nxt  = 1'b0;
		end
		else if (sk.pwm_tick)
		begin
			window_nxt = {window_r[6:0], sk.skipped};
			// Latched until the supervisor leaves normal switching
			if (bfs_count_ones(window_nxt) >= 4'(SKIP_LIMIT))
				fault_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			window_r <= SKIP_WINDOW_RST;
			fault_r  <= 1'b0;
		end
		else
		begin
			window_r <= window_nxt;
			fault_r  <= fault_nxt;
		end
	end

	assign sk.fault = fault_r;

	property p_skip_three;
		@(posedge clk_sys) disable iff (reset)
		(!sk.clear && sk.pwm_tick && bfs_count_ones({window_r[6:0], sk.skipped}) >= 4'h3)
			|=> sk.fault;
	endproperty
	a_skip_three: assert property (p_skip_three) else $error("Three skips did not latch fault");

	property p_skip_quiet;
		@(posedge clk_sys) disable iff (reset)
		(!fault_r && !sk.clear && sk.pwm_tick && bfs_count_ones({window_r[6:0], sk.skipped}) < 4'h3)
			|=> !sk.fault;
	endproperty
	a_skip_quiet: assert property (p_skip_quiet) else $error("Fault latched below three skips");

endmodule : bfs_skip_window

/* rtl/bfs_supervisor.sv */
// Fault supervisor for a synchronous buck regulator: gating, hiccup and power-good
// How it works
// - After startup, high-side overcurrent turns both switches off and starts 200 ms hiccup.
// - High-side current back under limit and no other fault resumes normal switching.
// - After startup, low-side overcurrent skips high-side on-cycles until it clears.
// - Skipped cycles tracked over eight cycles; three skips latch a low-side fault.
// - A latched low-side fault stops switching and starts 200 ms hiccup.
// - After a low-side fault, resume only when overcurrent gone and no other fault.
// - After startup, negative low-side overcurrent latches the negative protection state.
// - In that state low side off, high side on, until high-side current crosses zero.
// - Then both switches off until next PWM clock, when latch clears and switching resumes.
// - Power-good rises only after soft-start done and feedback inside regulation window.
// - Feedback over 120 percent, qualified 1 to 2 us, starts 200 ms hiccup.
// - Feedback back under 120 percent lets normal operation resume.
// - After startup, feedback under 70 percent together with low-side overcurrent starts 200 ms hiccup.
// - Feedback under 70 percent alone raises no undervoltage fault.
// - Undervoltage releases once feedback above 70 percent and low-side overcurrent cleared.
// - Input lockout enables above rising threshold flag, disables below falling flag.
// - After power-good, over-temperature shuts down and holds power-good low.
// - Thermal restart only once below 123 C, through a fresh soft-start.
// - Bias supply under 2.7 V switches off; restart through startup above 2.9 V.
// - Supply lockouts and thermal fault force reset state, then start per enable.
// - Any fault forces power-good low until cleared through a soft-start attempt.
`timescale 1ns/1ps
module bfs_supervisor
	import bfs_pkg::*;
#(
	parameter int HICCUP_CYCLES = HICCUP_CYC
)
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// Digital controls
	input  wire logic enable_in,
	input  wire logic pwm_clock_tick,
	input  wire logic pwm_high_request,
	// Analog comparator flags
	input  wire logic high_side_overcurrent,
	input  wire logic low_side_overcurrent,
	input  wire logic low_side_negative_overcurrent,
	input  wire logic feedback_sense_over,
	input  wire logic feedback_sense_under,
	input  wire logic feedback_sense_in_window,
	input  wire logic power_input_supply_above_rise,
	input  wire logic power_input_supply_below_fall,
	input  wire logic analog_bias_supply_below_off,
	input  wire logic analog_bias_supply_above_on,
	input  wire logic over_temperature,
	input  wire logic temperature_below_restart,
	input  wire logic soft_start_done,
	input  wire logic high_side_zero_cross,
	// Switch drive
	output logic      high_side_drive,
	output logic      low_side_drive,
	// Soft-start and power-good
	output logic      soft_start_run,
	output logic      power_good_output,
	output logic      power_good_pull_oe,
	// Status
	output logic      hiccup_active,
	output logic      supply_lockout
);

	// ****************************************
	// Synchronisers
	// ****************************************
	logic [FLG_W-1:0] flag_meta_r;
	logic [FLG_W-1:0] flag_s_r;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			flag_meta_r <= '0;
			flag_s_r    <= '0;
		end
		else
		begin
			// Analog flags are asynchronous to the system clock
			flag_meta_r <= {high_side_zero_cross, soft_start_done, temperature_below_restart,
				over_temperature, analog_bias_supply_above_on, analog_bias_supply_below_off,
				power_input_supply_below_fall, power_input_supply_above_rise,
				feedback_sense_in_window, feedback_sense_under, feedback_sense_over,
				low_side_negative_overcurrent, low_side_overcurrent,
				high_side_overcurrent};
			flag_s_r    <= flag_meta_r;
		end
	end

	logic high_side_overcurrent_s, low_side_overcurrent_s, negoc_s, fbov_s, fbuv_s, fbwin_s, ssdone_s, zero_s;
	assign high_side_overcurrent_s   = flag_s_r[FLG_HIGH_SIDE_OVERCURRENT];
	assign low_side_overcurrent_s   = flag_s_r[FLG_LOW_SIDE_OVERCURRENT];
	assign negoc_s  = flag_s_r[FLG_NEGOC];
	assign fbov_s   = flag_s_r[FLG_FBOV];
	assign fbuv_s   = flag_s_r[FLG_FBUV];
	assign fbwin_s  = flag_s_r[FLG_FBWIN];
	assign ssdone_s = flag_s_r[FLG_SSDONE];
	assign zero_s   = flag_s_r[FLG_ZERO];

	// ****************************************
	// Lockouts
	// ****************************************
	logic pv_lock_r, pv_lock_nxt;
	logic av_lock_r, av_lock_nxt;
	logic ot_lock_r, ot_lock_nxt;
	logic lock_any;
	bfs_state_type state_r, state_nxt;
	logic pg_r, pg_nxt;

	always_comb
	begin
		pv_lock_nxt = pv_lock_r;
		av_lock_nxt = av_lock_r;
		ot_lock_nxt = ot_lock_r;
		// Hysteresis from two threshold flags; the flag that sets the lockout wins
		if (flag_s_r[FLG_PVFALL])
			pv_lock_nxt = 1'b1;
		else if (flag_s_r[FLG_PVRISE])
			pv_lock_nxt = 1'b0;
		if (flag_s_r[FLG_AVLOW])
			av_lock_nxt = 1'b1;
		else if (flag_s_r[FLG_AVOK])
			av_lock_nxt = 1'b0;
		if (pg_r && flag_s_r[FLG_OT])
			ot_lock_nxt = 1'b1;
		else if (flag_s_r[FLG_OTCOOL])
			ot_lock_nxt = 1'b0;
	end

	assign lock_any = pv_lock_r || av_lock_r || ot_lock_r;

	// ****************************************
	// Overvoltage qualification
	// ****************************************
	logic [OV_CNT_W-1:0] ov_cnt_r, ov_cnt_nxt;
	logic                ov_fault;

	always_comb
	begin
		ov_cnt_nxt = '0;
		if (fbov_s && (state_r == BFS_SOFT || state_r == BFS_RUN))
			ov_cnt_nxt = (ov_cnt_r == OV_CNT_W'(OV_QUAL_CYC)) ? ov_cnt_r : ov_cnt_r + 1'b1;
	end

	assign ov_fault = (ov_cnt_r == OV_CNT_W'(OV_QUAL_CYC));

	// ****************************************
	// Main sequence
	// ****************************************
	bfs_skip_if sk ();
	logic [HICCUP_CNT_W-1:0] hic_cnt_r, hic_cnt_nxt;
	logic run_fault;
	logic fault_present;

	// Undervoltage needs low-side overcurrent too; feedback low alone is ignored
	assign run_fault = high_side_overcurrent_s || sk.fault || (fbuv_s && low_side_overcurrent_s);
	assign fault_present = high_side_overcurrent_s || low_side_overcurrent_s || fbov_s || fbuv_s;

	always_comb
	begin
		state_nxt   = state_r;
		hic_cnt_nxt = '0;
		case (state_r)
			BFS_POR:
			begin
				if (!lock_any && enable_in)
					state_nxt = BFS_SOFT;
			end
			BFS_SOFT:
			begin
				if (ov_fault)
					state_nxt = BFS_HICCUP;
				else if (ssdone_s)
					state_nxt = BFS_RUN;
			end
			BFS_RUN:
			begin
				if (ov_fault || run_fault)
					state_nxt = BFS_HICCUP;
			end
			BFS_HICCUP:
			begin
				hic_cnt_nxt = hic_cnt_r + 1'b1;
				if (hic_cnt_r == HICCUP_CNT_W'(HICCUP_CYCLES - 1))
				begin
					// Another full period while any fault is still seen
					hic_cnt_nxt = '0;
					if (!fault_present)
						state_nxt = BFS_SOFT;
				end
			end
			default:
			begin
				state_nxt = BFS_POR;
			end
		endcase
		// Lockouts and disable override every state
		if (lock_any || !enable_in)
		begin
			state_nxt   = BFS_POR;
			hic_cnt_nxt = '0;
		end
	end

	// ****************************************
	// Negative overcurrent and gating
	// ****************************************
	bfs_neg_type neg_r, neg_nxt;
	logic skip_r, skip_nxt;
	logic hs_r, hs_nxt;
	logic ls_r, ls_nxt;

	always_comb
	begin
		neg_nxt  = neg_r;
		skip_nxt = skip_r;
		if (state_r != BFS_RUN)
			neg_nxt = BFS_NEG_IDLE;
		else
			case (neg_r)
				BFS_NEG_IDLE:
				begin
					if (negoc_s)
						neg_nxt = BFS_NEG_HS;
				end
				BFS_NEG_HS:
				begin
					if (zero_s)
						neg_nxt = BFS_NEG_OFF;
				end
				BFS_NEG_OFF:
				begin
					if (pwm_clock_tick)
						neg_nxt = BFS_NEG_IDLE;
				end
				default:
				begin
					neg_nxt = BFS_NEG_IDLE;
				end
			endcase
		// Skip decision held for a whole PWM cycle
		if (state_r != BFS_RUN)
			skip_nxt = 1'b0;
		else if (pwm_clock_tick)
			skip_nxt = low_side_overcurrent_s;
	end

	always_comb
	begin
		hs_nxt = 1'b0;
		ls_nxt = 1'b0;
		if (state_r == BFS_SOFT)
		begin
			hs_nxt = pwm_high_request;
			ls_nxt = !pwm_high_request;
		end
		else if (state_r == BFS_RUN)
		begin
			case (neg_r)
				BFS_NEG_HS:
				begin
					hs_nxt = 1'b1;
					ls_nxt = 1'b0;
				end
				BFS_NEG_OFF:
				begin
					hs_nxt = 1'b0;
					ls_nxt = 1'b0;
				end
				default:
				begin
					hs_nxt = pwm_high_request && !skip_r;
					ls_nxt = !pwm_high_request || skip_r;
				end
			endcase
		end
	end

	// Power-good only in normal switching with feedback in window
	assign pg_nxt = (state_r == BFS_RUN) && ssdone_s && fbwin_s && !run_fault && !ov_fault
		&& !lock_any;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state_r   <= BFS_POR;
			pv_lock_r <= 1'b1;
			av_lock_r <= 1'b1;
			ot_lock_r <= 1'b0;
			ov_cnt_r  <= '0;
			hic_cnt_r <= '0;
			neg_r     <= BFS_NEG_IDLE;
			skip_r    <= 1'b0;
			hs_r      <= 1'b0;
			ls_r      <= 1'b0;
			pg_r      <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			pv_lock_r <= pv_lock_nxt;
			av_lock_r <= av_lock_nxt;
			ot_lock_r <= ot_lock_nxt;
			ov_cnt_r  <= ov_cnt_nxt;
			hic_cnt_r <= hic_cnt_nxt;
			neg_r     <= neg_nxt;
			skip_r    <= skip_nxt;
			hs_r      <= hs_nxt;
			ls_r      <= ls_nxt;
			pg_r      <= pg_nxt;
		end
	end

	assign sk.pwm_tick = pwm_clock_tick && (state_r == BFS_RUN);
	assign sk.skipped  = low_side_overcurrent_s;
	assign sk.clear    = (state_r != BFS_RUN);

	bfs_skip_window u_skip (
		.clk_sys (clk_sys),
		.reset   (reset),
		.sk      (sk)
	);

	assign high_side_drive    = hs_r;
	assign low_side_drive     = ls_r;
	// Low restarts the ramp, so every retry is a fresh soft-start
	assign soft_start_run     = (state_r == BFS_SOFT) || (state_r == BFS_RUN);
	assign power_good_output  = pg_r;
	assign power_good_pull_oe = !pg_r;
	assign hiccup_active      = (state_r == BFS_HICCUP);
	assign supply_lockout     = lock_any;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_high_side_overcurrent;
		(state_r == BFS_RUN && high_side_overcurrent_s && !lock_any && enable_in) |=> hiccup_active ##1 (!hs_r && !ls_r);
	endproperty
	a_high_side_overcurrent: assert property (p_high_side_overcurrent) else $error("High-side overcurrent missed hiccup");

	property p_skip;
		(state_r == BFS_RUN && neg_r == BFS_NEG_IDLE && skip_r) |=> !hs_r;
	endproperty
	a_skip: assert property (p_skip) else $error("High side driven on a skipped cycle");

	property p_lsfault;
		(state_r == BFS_RUN && sk.fault && !lock_any && enable_in) |=> hiccup_active;
	endproperty
	a_lsfault: assert property (p_lsfault) else $error("Low-side fault missed hiccup");

	property p_neg;
		(state_r == BFS_RUN && neg_r == BFS_NEG_IDLE && negoc_s && state_nxt == BFS_RUN)
			|=> (neg_r == BFS_NEG_HS) ##1 (hs_r && !ls_r);
	endproperty
	a_neg: assert property (p_neg) else $error("Negative overcurrent drive wrong");

	property p_tri;
		(neg_r == BFS_NEG_OFF && state_r == BFS_RUN) |=> (!hs_r && !ls_r);
	endproperty
	a_tri: assert property (p_tri) else $error("Switches not off after zero cross");

	property p_pg;
		power_good_output |-> $past(state_r == BFS_RUN && ssdone_s && fbwin_s);
	endproperty
	a_pg: assert property (p_pg) else $error("Power-good without soft-start done");

	property p_ov;
		(ov_cnt_r == OV_CNT_W'(OV_QUAL_CYC) && state_r == BFS_RUN && !lock_any && enable_in)
			|=> hiccup_active;
	endproperty
	a_ov: assert property (p_ov) else $error("Qualified overvoltage missed hiccup");

	property p_ov_early;
		// Watches the qualifier itself, so other faults may still end the run meanwhile
		(state_r == BFS_RUN && $rose(fbov_s) && !run_fault) |=> !ov_fault [*8];
	endproperty
	a_ov_early: assert property (p_ov_early) else $error("Overvoltage acted before delay");

	property p_uv_alone;
		(state_r == BFS_RUN && fbuv_s && !low_side_overcurrent_s && !high_side_overcurrent_s && !sk.fault && !ov_fault
			&& !lock_any && enable_in) |=> state_r == BFS_RUN;
	endproperty
	a_uv_alone: assert property (p_uv_alone) else $error("Undervoltage alone left run");

	property p_lock;
		lock_any |=> (state_r == BFS_POR && !power_good_output) ##1 (!hs_r && !ls_r);
	endproperty
	a_lock: assert property (p_lock) else $error("Lockout did not force reset state");

	c_hiccup:  cover property (state_r == BFS_RUN ##1 hiccup_active);
	c_neg:     cover property (neg_r == BFS_NEG_HS ##[1:50] neg_r == BFS_NEG_OFF);
	c_pg:      cover property ($rose(power_good_output));
	c_ls_trip: cover property ($rose(sk.fault));

endmodule : bfs_supervisor

/* testbench/bfs_analog_model.sv */
// Behavioural model of the PWM clock, zero-cross comparator and soft-start ramp
`timescale 1ns/1ps
module bfs_analog_model
#(
	parameter int PWM_PERIOD = 16,
	parameter int SS_CYCLES  = 20,
	parameter int ZC_CYCLES  = 8
)
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// From the supervisor
	input  wire logic soft_start_run,
	input  wire logic high_side_drive,
	input  wire logic low_side_drive,
	// To the supervisor
	output logic      pwm_clock_tick,
	output logic      pwm_high_request,
	output logic      soft_start_done,
	output logic      high_side_zero_cross
);
	int pwm_cnt_r;
	int ss_cnt_r;
	int zc_cnt_r;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pwm_cnt_r            <= 0;
			ss_cnt_r             <= 0;
			zc_cnt_r             <= 0;
			pwm_clock_tick       <= 1'b0;
			pwm_high_request     <= 1'b0;
			soft_start_done      <= 1'b0;
			high_side_zero_cross <= 1'b0;
		end
		else
		begin
			pwm_cnt_r        <= (pwm_cnt_r == PWM_PERIOD - 1) ? 0 : pwm_cnt_r + 1;
			pwm_clock_tick   <= (pwm_cnt_r == PWM_PERIOD - 1);
			pwm_high_request <= (pwm_cnt_r < PWM_PERIOD / 2);
			// Ramp restarts from zero whenever the run enable drops
			ss_cnt_r        <= soft_start_run ? ((ss_cnt_r < SS_CYCLES) ? ss_cnt_r + 1 : ss_cnt_r) : 0;
			soft_start_done <= soft_start_run && (ss_cnt_r >= SS_CYCLES);
			// Reverse current only decays while the high side alone conducts
			zc_cnt_r             <= (high_side_drive && !low_side_drive) ? zc_cnt_r + 1 : 0;
			high_side_zero_cross <= high_side_drive && !low_side_drive && (zc_cnt_r >= ZC_CYCLES);
		end
	end
endmodule : bfs_analog_model

/* testbench/test_buck_fault_supervisor.sv */
// Self-checking bench of the buck fault supervisor
`timescale 1ns/1ps
`define CHK(g_v, e_v) begin tests_run++; if ((g_v) !== (e_v)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g_v), (e_v)); end end
module test_buck_fault_supervisor;
	localparam int PP = 16;

	logic clk_sys;
	logic reset;
	logic enable_in;
	logic high_side_overcurrent;
	logic low_side_overcurrent;
	logic low_side_negative_overcurrent;
	logic feedback_sense_over;
	logic feedback_sense_under;
	logic feedback_sense_in_window;
	logic power_input_supply_above_rise;
	logic power_input_supply_below_fall;
	logic analog_bias_supply_below_off;
	logic analog_bias_supply_above_on;
	logic over_temperature;
	logic temperature_below_restart;
	wire  pwm_clock_tick;
	wire  pwm_high_request;
	wire  soft_start_done;
	wire  high_side_zero_cross;
	logic high_side_drive;
	logic low_side_drive;
	logic soft_start_run;
	logic power_good_output;
	logic power_good_pull_oe;
	logic hiccup_active;
	logic supply_lockout;
	int   miscompares;
	int   tests_run;

	bfs_supervisor #(.HICCUP_CYCLES(64)) uut (.clk_sys, .reset, .enable_in, .pwm_clock_tick,
		.pwm_high_request, .high_side_overcurrent, .low_side_overcurrent,
		.low_side_negative_overcurrent, .feedback_sense_over, .feedback_sense_under,
		.feedback_sense_in_window, .power_input_supply_above_rise,
		.power_input_supply_below_fall, .analog_bias_supply_below_off,
		.analog_bias_supply_above_on, .over_temperature, .temperature_below_restart,
		.soft_start_done, .high_side_zero_cross, .high_side_drive, .low_side_drive,
		.soft_start_run, .power_good_output, .power_good_pull_oe, .hiccup_active,
		.supply_lockout);

	bfs_analog_model #(.PWM_PERIOD(PP)) far_side (.clk_sys, .reset, .soft_start_run,
		.high_side_drive, .low_side_drive, .pwm_clock_tick, .pwm_high_request,
		.soft_start_done, .high_side_zero_cross);

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	function automatic logic pick(input int w);
		case (w)
			0: return power_good_output;
			1: return hiccup_active;
			2: return supply_lockout;
			3: return high_side_drive;
			4: return soft_start_run;
			5: return soft_start_done;
			default: return pwm_clock_tick;
		endcase
	endfunction : pick

	// Bounded wait; running out of the bound ends the run
	task automatic wait_for(input int w, input logic v, input int lim);
		int n;
		n = 0;
		tests_run++;
		@(negedge clk_sys);
		while (pick(w) !== v && n < lim)
		begin
			@(negedge clk_sys);
			n++;
		end
		if (pick(w) !== v)
		begin
			miscompares++;
			$display("BAD t=%0t wait %0d got=%h exp=%h", $time, w, pick(w), v);
			summarize();
		end
	endtask : wait_for

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_start();
		logic r;
		@(negedge clk_sys);
		`CHK(supply_lockout, 1'b1)
		`CHK(power_good_pull_oe, 1'b1)
		`CHK(soft_start_run, 1'b0)
		@(posedge clk_sys);
		reset <= 1'b0;
		wait_for(5, 1'b1, 60);
		cyc(8);
		`CHK(power_good_output, 1'b0)
		@(posedge clk_sys);
		feedback_sense_in_window <= 1'b1;
		wait_for(0, 1'b1, 10);
		`CHK(power_good_pull_oe, 1'b0)
		`CHK(supply_lockout, 1'b0)
		for (int i = 0; i < PP; i++)
		begin
			r = pwm_high_request;
			@(negedge clk_sys);
			`CHK(high_side_drive, r)
			`CHK(low_side_drive, ~r)
		end
	endtask : t_start

	task automatic t_high_side_overcurrent();
		@(posedge clk_sys);
		high_side_overcurrent <= 1'b1;
		wait_for(1, 1'b1, 8);
		`CHK(power_good_output, 1'b0)
		cyc(2);
		`CHK({high_side_drive, low_side_drive}, 2'h0)
		cyc(100);
		`CHK(hiccup_active, 1'b1)
		@(posedge clk_sys);
		high_side_overcurrent <= 1'b0;
		wait_for(4, 1'b1, 140);
		`CHK(power_good_output, 1'b0)
		wait_for(0, 1'b1, 100);
	endtask : t_high_side_overcurrent

	task automatic t_skip();
		wait_for(6, 1'b1, PP + 4);
		@(posedge clk_sys);
		low_side_overcurrent <= 1'b1;
		wait_for(6, 1'b1, PP + 4);
		cyc(6);
		`CHK({high_side_drive, low_side_drive}, 2'h1)
		wait_for(6, 1'b1, PP + 4);
		@(posedge clk_sys);
		low_side_overcurrent <= 1'b0;
		wait_for(6, 1'b1, PP + 4);
		wait_for(6, 1'b1, PP + 4);
		`CHK(hiccup_active, 1'b0)
		@(posedge clk_sys);
		low_side_overcurrent <= 1'b1;
		wait_for(6, 1'b1, PP + 4);
		@(posedge clk_sys);
		low_side_overcurrent <= 1'b0;
		wait_for(1, 1'b1, 8);
		cyc(3);
		`CHK({high_side_drive, low_side_drive}, 2'h0)
		wait_for(0, 1'b1, 400);
	endtask : t_skip

	task automatic t_uv();
		@(posedge clk_sys);
		feedback_sense_under <= 1'b1;
		cyc(40);
		`CHK(hiccup_active, 1'b0)
		@(posedge clk_sys);
		low_side_overcurrent <= 1'b1;
		wait_for(1, 1'b1, 8);
		@(posedge clk_sys);
		low_side_overcurrent <= 1'b0;
		feedback_sense_under <= 1'b0;
		wait_for(0, 1'b1, 400);
	endtask : t_uv

	task automatic t_ov();
		@(posedge clk_sys);
		feedback_sense_over <= 1'b1;
		cyc(190);
		`CHK(hiccup_active, 1'b0)
		wait_for(1, 1'b1, 205);
		@(posedge clk_sys);
		feedback_sense_over <= 1'b0;
		cyc(58);
		`CHK(hiccup_active, 1'b1)
		wait_for(1, 1'b0, 12);
		wait_for(0, 1'b1, 100);
	endtask : t_ov

	task automatic t_neg();
		wait_for(6, 1'b1, PP + 4);
		cyc(9);
		@(posedge clk_sys);
		low_side_negative_overcurrent <= 1'b1;
		wait_for(3, 1'b1, 6);
		`CHK(low_side_drive, 1'b0)
		@(posedge clk_sys);
		low_side_negative_overcurrent <= 1'b0;
		cyc(3);
		`CHK({high_side_drive, low_side_drive}, 2'h2)
		wait_for(3, 1'b0, 20);
		`CHK(low_side_drive, 1'b0)
		wait_for(3, 1'b1, 2 * PP + 4);
		`CHK(hiccup_active, 1'b0)
	endtask : t_neg

	task automatic t_thermal();
		@(posedge clk_sys);
		over_temperature          <= 1'b1;
		temperature_below_restart <= 1'b0;
		wait_for(2, 1'b1, 8);
		// Power-good and the state register trail the lockout by one edge
		cyc(1);
		`CHK(power_good_output, 1'b0)
		`CHK(soft_start_run, 1'b0)
		@(posedge clk_sys);
		over_temperature <= 1'b0;
		cyc(20);
		`CHK(supply_lockout, 1'b1)
		@(posedge clk_sys);
		temperature_below_restart <= 1'b1;
		wait_for(4, 1'b1, 10);
		`CHK(power_good_output, 1'b0)
		wait_for(0, 1'b1, 100);
	endtask : t_thermal

	// Input lockout, bias lockout, then enable low
	task automatic t_lockout(input int sel);
		@(posedge clk_sys);
		if (sel == 0)
			power_input_supply_below_fall <= 1'b1;
		else if (sel == 1)
			analog_bias_supply_below_off <= 1'b1;
		else
			enable_in <= 1'b0;
		power_input_supply_above_rise <= 1'b0;
		analog_bias_supply_above_on   <= 1'b0;
		wait_for(4, 1'b0, 8);
		// With enable low, the power-good register settles one edge after the state
		cyc(1);
		`CHK(power_good_output, 1'b0)
		`CHK(supply_lockout, 1'(sel != 2))
		@(posedge clk_sys);
		power_input_supply_below_fall <= 1'b0;
		analog_bias_supply_below_off  <= 1'b0;
		cyc(10);
		`CHK(supply_lockout, 1'(sel != 2))
		`CHK(soft_start_run, 1'b0)
		@(posedge clk_sys);
		power_input_supply_above_rise <= 1'b1;
		analog_bias_supply_above_on   <= 1'b1;
		enable_in                     <= 1'b1;
		wait_for(0, 1'b1, 100);
	endtask : t_lockout

	initial
	begin
		miscompares = 0;
		tests_run = 0;
		reset = 1'b1;
		enable_in = 1'b1;
		high_side_overcurrent = 1'b0;
		low_side_overcurrent = 1'b0;
		low_side_negative_overcurrent = 1'b0;
		feedback_sense_over = 1'b0;
		feedback_sense_under = 1'b0;
		feedback_sense_in_window = 1'b0;
		power_input_supply_above_rise = 1'b1;
		power_input_supply_below_fall = 1'b0;
		analog_bias_supply_below_off = 1'b0;
		analog_bias_supply_above_on = 1'b1;
		over_temperature = 1'b0;
		temperature_below_restart = 1'b1;
		repeat (6) @(posedge clk_sys);
		t_start();
		t_high_side_overcurrent();
		t_skip();
		t_uv();
		t_ov();
		t_neg();
		t_thermal();
		for (int s = 0; s < 3; s++)
			t_lockout(s);
		summarize();
	end
endmodule : test_buck_fault_supervisor
